// ===== umd_pkg.sv
// Package of constants for the modem, DMA and pin logic block
package umd_pkg;
   // Modem status register bit positions
   localparam int MSR_RING_EDGE_BIT = 2;
   localparam int MSR_RING_LEVEL_BIT = 6;
   // Modem control register bit positions
   localparam int MODEM_CTRL_RTS_BIT = 1;
   localparam int MODEM_CTRL_LOOP_BIT = 4;
   // FIFO control register bit positions
   localparam int FIFO_CTRL_EN_BIT = 0;
   localparam int FIFO_CTRL_DMA_MODE_BIT = 3;
   // Reset levels of the pins and of the internal state
   localparam logic RTS_N_RESET = 1'h1;
   localparam logic SERIAL_OUT_RESET = 1'h1;
   localparam logic RX_REQ_N_RESET = 1'h1;
   localparam logic RING_PIN_IDLE = 1'h1;
   localparam logic RING_LEVEL_RESET = 1'h0;
   localparam logic RING_EDGE_FLAG_RESET = 1'h0;
   // Receive DMA request states, one-hot
   typedef enum logic [1:0] {
      UMD_RX_IDLE = 2'h1,
      UMD_RX_ACTIVE = 2'h2
   } umd_rx_state_t;
endpackage

// ===== umd_pin_logic.sv
// Modem ring, request-to-send, receive DMA request and serial output pin logic
// Functional notes
// - Ring input level shown in status bit 6
// - Status bit 2 set on ring low-to-high
// - Ring rise raises interrupt when enabled
// - RTS active when control RTS bit set
// - RTS inactive on reset, loop, bit clear
// - Auto RTS threshold logic forces RTS inactive
// - DMA mode from bit 3 only in FIFO
// - Mode 0: request low while characters held
// - Mode 1: low at trigger until empty
// - Serial output marks high on reset
`timescale 1ns/10ps
module umd_pin_logic
   import umd_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic ring_n_in,
   input wire logic msr_read_in,
   input wire logic modem_int_enable_in,
   input wire logic [7:0] modem_control_reg_in,
   input wire logic [7:0] fifo_control_reg_in,
   input wire logic auto_rts_enable_in,
   input wire logic rx_threshold_reached_in,
   input wire logic rx_char_count_nonzero_in,
   input wire logic rx_trigger_or_timeout_in,
   input wire logic tx_serial_bit_in,
   output logic ring_status_out,
   output logic trailing_ring_edge_flag_out,
   output logic modem_int_out,
   output logic rts_n_out,
   output logic receiver_dma_request_n_out,
   output logic serial_out
);
   // Ring input synchroniser stages and the filtered ring level
   logic ring_s1_q;
   logic ring_s1_d;
   logic ring_s2_q;
   logic ring_s2_d;
   logic ring_s3_q;
   logic ring_s3_d;
   logic ring_q;
   logic ring_d;
   // Sticky trailing ring edge flag
   logic ring_edge_q;
   logic ring_edge_d;
   // Request-to-send and serial output registers
   logic rts_n_q;
   logic rts_n_d;
   logic serial_q;
   logic serial_d;
   // Receive DMA request state
   umd_rx_state_t rx_q;
   umd_rx_state_t rx_d;
   // Decoded controls and events
   logic ring_agree;
   logic ring_rise;
   logic loop_mode;
   logic dma_mode1;
   logic rx_start;

   // Second and third stages agree: the pin level has settled
   assign ring_agree = (ring_s2_q == ring_s3_q);

   // Ring pin is active low; the status bit shows its complement
   always_comb
   begin
      ring_s1_d = ring_n_in;
      ring_s2_d = ring_s1_q;
      ring_s3_d = ring_s2_q;
      ring_d = ring_q;
      if (ring_agree)
      begin
         ring_d = ~ring_s3_q;
      end
   end

   // Trailing edge: ring was active and the pin has settled high
   assign ring_rise = ring_q & ring_agree & ring_s3_q;

   // Flag sets on the edge; a set in the read cycle wins so no ring is lost
   always_comb
   begin
      ring_edge_d = ring_edge_q;
      if (msr_read_in)
      begin
         ring_edge_d = 1'h0;
      end
      if (ring_rise)
      begin
         ring_edge_d = 1'h1;
      end
   end

   // Loop mode and DMA mode select; mode 1 needs the FIFO enabled
   assign loop_mode = modem_control_reg_in[MODEM_CTRL_LOOP_BIT];
   assign dma_mode1 = fifo_control_reg_in[FIFO_CTRL_EN_BIT] & fifo_control_reg_in[FIFO_CTRL_DMA_MODE_BIT];

   // RTS control: active low when bit set, out of loop, below threshold
   always_comb
   begin
      rts_n_d = ~modem_control_reg_in[MODEM_CTRL_RTS_BIT];
      if (loop_mode)
      begin
         rts_n_d = 1'h1;
      end
      if (auto_rts_enable_in && rx_threshold_reached_in)
      begin
         rts_n_d = 1'h1;
      end
   end

   // Start condition: trigger or time-out in mode 1, any character in mode 0
   assign rx_start = dma_mode1 ? rx_trigger_or_timeout_in : rx_char_count_nonzero_in;

   // Receive DMA request state; both modes release once the receiver is empty
   always_comb
   begin
      rx_d = rx_q;
      unique case (rx_q)
         UMD_RX_IDLE:
         begin
            if (rx_start)
            begin
               rx_d = UMD_RX_ACTIVE;
            end
         end
         UMD_RX_ACTIVE:
         begin
            if (!rx_char_count_nonzero_in)
            begin
               rx_d = UMD_RX_IDLE;
            end
         end
         default:
         begin
            rx_d = UMD_RX_IDLE;
         end
      endcase
   end

   // Serial output follows the transmitter
   assign serial_d = tx_serial_bit_in;

   // State registers; reset loads only constants
   always_ff @(posedge clock_in)
   begin
      if (!nrst_in)
      begin
         ring_s1_q <= RING_PIN_IDLE;
         ring_s2_q <= RING_PIN_IDLE;
         ring_s3_q <= RING_PIN_IDLE;
         ring_q <= RING_LEVEL_RESET;
         ring_edge_q <= RING_EDGE_FLAG_RESET;
         rts_n_q <= RTS_N_RESET;
         serial_q <= SERIAL_OUT_RESET;
         rx_q <= UMD_RX_IDLE;
      end
      else
      begin
         ring_s1_q <= ring_s1_d;
         ring_s2_q <= ring_s2_d;
         ring_s3_q <= ring_s3_d;
         ring_q <= ring_d;
         ring_edge_q <= ring_edge_d;
         rts_n_q <= rts_n_d;
         serial_q <= serial_d;
         rx_q <= rx_d;
      end
   end

   // Outputs
   assign ring_status_out = ring_q;
   assign trailing_ring_edge_flag_out = ring_edge_q;
   assign modem_int_out = ring_edge_q & modem_int_enable_in;
   assign rts_n_out = rts_n_q;
   assign receiver_dma_request_n_out = (rx_q == UMD_RX_ACTIVE) ? 1'h0 : RX_REQ_N_RESET;
   assign serial_out = serial_q;

   // Checks: the ring has settled high after being active
   sequence s_ring_settled_high;
      ring_s2_q && ring_s3_q && ring_q;
   endsequence

   // A ring edge followed by a read that has no new edge beside it
   sequence s_rise_then_read;
      ring_rise ##1 (msr_read_in && !ring_rise);
   endsequence

   a_ring_status_level: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ring_agree |=> (ring_status_out == !$past(ring_s3_q)))
      else $error("ring status does not follow pin");
   a_ring_status_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !ring_agree |=> $stable(ring_status_out))
      else $error("ring status moved while pin unsettled");
   a_edge_flag_sets: assert property (@(posedge clock_in) disable iff (!nrst_in)
      s_ring_settled_high |=> trailing_ring_edge_flag_out)
      else $error("trailing ring flag not set");
   a_edge_flag_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (!ring_rise && !msr_read_in) |=> $stable(trailing_ring_edge_flag_out))
      else $error("trailing ring flag changed without cause");
   a_ring_int: assert property (@(posedge clock_in) disable iff (!nrst_in)
      s_ring_settled_high |=> (modem_int_out == modem_int_enable_in))
      else $error("modem interrupt does not follow ring edge");
   a_int_gate: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !modem_int_enable_in |-> !modem_int_out)
      else $error("modem interrupt raised while disabled");
   a_rts_active: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (modem_control_reg_in[MODEM_CTRL_RTS_BIT] && !loop_mode && !auto_rts_enable_in) |=> !rts_n_out)
      else $error("rts not active");
   a_rts_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
      !modem_control_reg_in[MODEM_CTRL_RTS_BIT] |=> rts_n_out)
      else $error("rts active with control bit clear");
   a_rts_loop: assert property (@(posedge clock_in) disable iff (!nrst_in)
      loop_mode |=> rts_n_out)
      else $error("rts active in loop mode");
   a_rts_auto: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (auto_rts_enable_in && rx_threshold_reached_in) |=> rts_n_out)
      else $error("auto rts did not deassert");
   a_rx_mode1_wait: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (dma_mode1 && !rx_trigger_or_timeout_in && receiver_dma_request_n_out) |=> receiver_dma_request_n_out)
      else $error("mode 1 request without trigger");
   a_rx_mode0: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (!dma_mode1 && rx_char_count_nonzero_in) |=> !receiver_dma_request_n_out)
      else $error("mode 0 request not low");
   a_rx_mode1_start: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (dma_mode1 && rx_trigger_or_timeout_in && receiver_dma_request_n_out) |=> !receiver_dma_request_n_out)
      else $error("mode 1 request not raised at trigger");
   a_rx_mode1_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (!receiver_dma_request_n_out && rx_char_count_nonzero_in) |=> !receiver_dma_request_n_out)
      else $error("dma request released early");
   a_rx_release: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (!receiver_dma_request_n_out && !rx_char_count_nonzero_in) |=> receiver_dma_request_n_out)
      else $error("dma request held with receiver empty");
   a_edge_flag_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
      (msr_read_in && !ring_rise) |=> !trailing_ring_edge_flag_out)
      else $error("read did not clear flag");
   a_edge_flag_once: assert property (@(posedge clock_in) disable iff (!nrst_in)
      s_rise_then_read |=> !trailing_ring_edge_flag_out)
      else $error("ring edge reported twice");
   a_serial_reset: assert property (@(posedge clock_in)
      !nrst_in |=> serial_out)
      else $error("serial output not marking after reset");
   a_serial_follow: assert property (@(posedge clock_in) disable iff (!nrst_in)
      1'h1 |=> (serial_out == $past(tx_serial_bit_in)))
      else $error("serial output does not follow transmitter");
   a_reset_levels: assert property (@(posedge clock_in)
      !nrst_in |=> (rts_n_out && receiver_dma_request_n_out && !trailing_ring_edge_flag_out && !ring_status_out))
      else $error("outputs not at reset levels");
endmodule

// ===== umd_far_model.sv
// Far-side model: receive buffer count drained by a DMA controller
`timescale 1ns/10ps
module umd_far_model
(
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic req_n_in,
   input wire logic burst_in,
   input wire logic [3:0] load_in,
   output logic nonzero_out
);
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic gap_q;
   logic gap_d;
   // Burst drains every cycle; single mode leaves a bus cycle between transfers
   always_comb
   begin
      cnt_d = cnt_q + 5'(load_in);
      gap_d = 1'h0;
      if (!req_n_in && cnt_q != 5'h0 && !gap_q)
      begin
         cnt_d = cnt_d - 5'h1;
         gap_d = !burst_in;
      end
   end
   // Count register
   always_ff @(posedge clock_in)
   begin
      cnt_q <= nrst_in ? cnt_d : 5'h0;
      gap_q <= nrst_in ? gap_d : 1'h0;
   end
   // Receiver holds at least one character
   assign nonzero_out = cnt_q != 5'h0;
endmodule

// ===== umd_pin_logic_tb.sv
// Self-checking bench for the modem, DMA and pin logic block
`timescale 1ns/10ps
module umd_pin_logic_tb;
   import umd_pkg::*;
   logic clock_in = 1'h0, nrst_in = 1'h0, ring_n = 1'h1, rd = 1'h0, ien = 1'h0, aut = 1'h0, thr = 1'h0;
   logic trig = 1'h0, tx = 1'h0;
   logic [7:0] ctrl_reg = 8'h02, fifo_reg = 8'h00;
   logic [3:0] load = 4'h0;
   logic nz, ring_st, flag, irq, rts_n, req_n, ser;
   int mismatches = 0, n_checks = 0, seed = 33474, i;
   umd_pin_logic umd_pin_logic_inst (.clock_in(clock_in), .nrst_in(nrst_in), .ring_n_in(ring_n),
      .msr_read_in(rd), .modem_int_enable_in(ien), .modem_control_reg_in(ctrl_reg), .fifo_control_reg_in(fifo_reg),
      .auto_rts_enable_in(aut), .rx_threshold_reached_in(thr), .rx_char_count_nonzero_in(nz),
      .rx_trigger_or_timeout_in(trig), .tx_serial_bit_in(tx), .ring_status_out(ring_st),
      .trailing_ring_edge_flag_out(flag), .modem_int_out(irq), .rts_n_out(rts_n),
      .receiver_dma_request_n_out(req_n), .serial_out(ser));
   // The controller bursts only in mode 1, which needs the FIFO enabled
   umd_far_model umd_far_model_inst (.clock_in(clock_in), .nrst_in(nrst_in), .req_n_in(req_n),
      .burst_in(fifo_reg[FIFO_CTRL_EN_BIT] & fifo_reg[FIFO_CTRL_DMA_MODE_BIT]), .load_in(load), .nonzero_out(nz));
   // Clock
   initial
   begin
      forever #5 clock_in = ~clock_in;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Waits n edges, then looks once outputs have settled
   task automatic wt(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   // One-cycle status register read
   task automatic rd_pulse;
      @(posedge clock_in);
      rd <= 1'h1;
      @(posedge clock_in);
      rd <= 1'h0;
   endtask
   // RTS is active only with the bit set, out of loop and, when auto RTS is on, below threshold
   function automatic logic exp_rts(input logic [7:0] m, input logic a, input logic t);
      return !(m[MODEM_CTRL_RTS_BIT] && !m[MODEM_CTRL_LOOP_BIT] && !(a && t));
   endfunction
   // Mode 1 waits for the trigger; mode 0 requests as soon as a character is held
   function automatic logic exp_req_n(input logic [7:0] f);
      return f[FIFO_CTRL_EN_BIT] && f[FIFO_CTRL_DMA_MODE_BIT];
   endfunction
   // Loads characters, then waits for the request to fall back once drained
   task automatic dma(input logic [7:0] f);
      @(posedge clock_in);
      fifo_reg <= f;
      load <= 4'h3;
      @(posedge clock_in);
      load <= 4'h0;
      wt(3);
      chk(8'(req_n), 8'(exp_req_n(f)));
      @(posedge clock_in);
      trig <= 1'h1;
      @(posedge clock_in);
      trig <= 1'h0;
      wt(1);
      chk(8'(req_n), 8'h0);
      for (i = 0; i < 40 && req_n !== 1'h1; i++)
      begin
         wt(1);
      end
      chk(8'({req_n, nz}), 8'h2);
   endtask
   // Prints the verdict and ends the run
   task automatic give_verdict;
      if (mismatches == 0 && n_checks > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Main sequence
   initial
   begin
      wt(15);
      chk(8'({rts_n, ser, req_n}), 8'h7);
      @(posedge clock_in);
      nrst_in <= 1'h1;
      repeat (200)
      begin
         @(posedge clock_in);
         ctrl_reg <= 8'($random(seed));
         aut <= 1'($random(seed));
         thr <= 1'($random(seed));
         tx <= 1'($random(seed));
         wt(1);
         chk(8'(rts_n), 8'(exp_rts(ctrl_reg, aut, thr)));
         chk(8'(ser), 8'(tx));
      end
      // Ring active, then released with the interrupt enabled, then read
      @(posedge clock_in);
      ring_n <= 1'h0;
      wt(6);
      chk(8'({ring_st, flag}), 8'h2);
      @(posedge clock_in);
      ring_n <= 1'h1;
      ien <= 1'h1;
      wt(5);
      chk(8'({ring_st, flag, irq}), 8'h3);
      rd_pulse();
      wt(1);
      chk(8'({flag, irq}), 8'h0);
      // Read lands in the cycle of the ring edge: the set must win
      @(posedge clock_in);
      ring_n <= 1'h0;
      wt(6);
      @(posedge clock_in);
      ring_n <= 1'h1;
      repeat (2) @(posedge clock_in);
      rd_pulse();
      wt(1);
      chk(8'({flag, irq}), 8'h3);
      rd_pulse();
      wt(1);
      chk(8'({flag, irq}), 8'h0);
      // Second reset in mid-run with RTS requested and a space on the transmitter
      @(posedge clock_in);
      nrst_in <= 1'h0;
      ctrl_reg <= 8'h02;
      aut <= 1'h0;
      tx <= 1'h0;
      wt(2);
      chk(8'({rts_n, ser, req_n, flag}), 8'hE);
      @(posedge clock_in);
      nrst_in <= 1'h1;
      wt(2);
      chk(8'({rts_n, ser}), 8'h0);
      // Mode select bit ignored with FIFO off, mode 0 and mode 1 with FIFO on
      dma(8'h08);
      dma(8'h01);
      dma(8'h09);
      give_verdict();
   end
   // Watchdog: the tests need well under a thousand cycles
   initial
   begin
      #20us;
      mismatches++;
      give_verdict();
   end
endmodule
